// ===== src/temp_alert_pkg.sv
// Constants, field layout and carrier types for the temperature alert block
// How it works
// - Comparator mode: alarm after N readings at/above upper
// - Comparator alarm holds until N readings at/below lower
// - Interrupt mode: alarm after N readings at/above upper
// - Interrupt alarm cleared by any register read
// - Interrupt alarm cleared by writing sleep select one
// - Then re-armed on N readings at/below lower
// - Cycle repeats; general reset returns comparator mode
// - Limits reset to 75 and 80 degree patterns
// - Limit bits 3:0 read zero, 15:4 writable
// - Limits signed like result, high byte first
// - Result is 16-bit two's complement, 1/128 degree
// - Result reads zero until first conversion
// - First byte: 7-bit address, then direction bit
// - Device acknowledges its address on ninth clock
// - Incoming bits sampled on serial clock rising edge
// - Data never changes while clock is high
// - Every byte goes most significant bit first
// - Bus rates up to 400 kHz and 3.4 MHz
// - Fault count field bits 12:11 selects N 1..4
// - Level select: zero active low, one active high
package temp_alert_pkg;

    // ==========================================================
    // Register indices
    localparam logic [1:0]  IDX_RESULT  = 2'h0;
    localparam logic [1:0]  IDX_CONFIG  = 2'h1;
    localparam logic [1:0]  IDX_LOWER   = 2'h2;
    localparam logic [1:0]  IDX_UPPER   = 2'h3;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RESULT_RST  = 16'h0000;
    localparam logic [15:0] LOWER_RST   = 16'h2580;
    localparam logic [15:0] UPPER_RST   = 16'h2800;
    localparam logic [15:0] CONFIG_RST  = 16'h4080;

    // ==========================================================
    // Field layout
    localparam logic [15:0] LIMIT_MASK  = 16'hfff0;
    localparam logic [15:0] CONFIG_WMSK = 16'h9fc0;
    localparam int          CFG_STATUS  = 5;
    localparam int          CFG_SLEEP   = 8;
    localparam int          CFG_LATCH   = 9;
    localparam int          CFG_LEVEL   = 10;
    localparam int          CFG_FCNT_LO = 11;
    localparam int          CFG_SHOT    = 15;

    // ==========================================================
    // Serial framing
    localparam logic [3:0]  BIT_LAST    = 4'h7;
    localparam logic [3:0]  BIT_ACK     = 4'h8;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_ADDR  = 3'b001,
        PH_INDEX = 3'b010,
        PH_WR_HI = 3'b011,
        PH_WR_LO = 3'b100,
        PH_RD_HI = 3'b101,
        PH_RD_LO = 3'b110
    } phase_e;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } conv_s;

endpackage

// ===== src/temp_alert_core.sv
// Temperature threshold alert logic with its two-wire register target
`timescale 1ns/1ps
module temp_alert_core #(
    parameter logic [6:0] DEV_ADDR = 7'h48   // Arbitrary target address
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  scl_clk,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire temp_alert_pkg::conv_s conv,
    input  wire logic                  general_reset,
    output logic                       alert,
    output logic                       sleep_select,
    output logic                       single_shot
);

    // ==========================================================
    // Link clock domain: capture each bit on the rising edge
    logic       lrst_a_r;
    logic       lrst_b_r;
    logic       lbit_r;
    logic       ltgl_r;

    always_ff @(posedge scl_clk) begin
        lrst_a_r <= rst_n;
        lrst_b_r <= lrst_a_r;
    end

    always_ff @(posedge scl_clk) begin
        if (!lrst_b_r) begin
            lbit_r <= 1'b1;
            ltgl_r <= 1'b0;
        end else begin
            lbit_r <= sda_in;
            ltgl_r <= ~ltgl_r;
        end
    end

    // ==========================================================
    // Synchronisers into the system domain
    // Bit value is held a whole clock period, but it changes on the same edge as
    // the toggle and passes equal synchroniser depth, so both are seen in one cycle.
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic [1:0] tgl_s_r;
    logic [1:0] bit_s_r;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       tgl_d_r;

    always_ff @(posedge clk_sys) begin
        scl_s_r <= {scl_s_r[0], scl_in};
        sda_s_r <= {sda_s_r[0], sda_in};
        tgl_s_r <= {tgl_s_r[0], ltgl_r};
        bit_s_r <= {bit_s_r[0], lbit_r};
        scl_d_r <= scl_s_r[1];
        sda_d_r <= sda_s_r[1];
        tgl_d_r <= tgl_s_r[1];
    end

    logic start_det;
    logic stop_det;
    logic bit_evt;
    logic scl_fall;
    logic rx_bit;

    assign start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
    assign stop_det  = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
    assign bit_evt   = tgl_s_r[1] ^ tgl_d_r;
    assign scl_fall  = scl_d_r && !scl_s_r[1];
    assign rx_bit    = bit_s_r[1];

    // ==========================================================
    // Registers
    logic [15:0] result_r;
    logic [15:0] lower_r;
    logic [15:0] upper_r;
    logic [15:0] config_r;
    logic        act_r;
    logic        level_r;

    function automatic logic [15:0] reg_read(input logic [1:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            temp_alert_pkg::IDX_RESULT: v = result_r;
            temp_alert_pkg::IDX_CONFIG: begin
                v = config_r;
                v[temp_alert_pkg::CFG_STATUS] = level_r;
            end
            temp_alert_pkg::IDX_LOWER:  v = lower_r;
            temp_alert_pkg::IDX_UPPER:  v = upper_r;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Byte framing
    temp_alert_pkg::phase_e phase_r;
    logic [3:0]  cnt_r;
    logic [6:0]  shreg_r;
    logic        ack_r;
    logic [7:0]  tx_r;
    logic [7:0]  lo_hold_r;
    logic [7:0]  hi_hold_r;
    logic [1:0]  idx_r;
    logic        rd_clr_r;
    logic        wr_r;
    logic [15:0] wr_data_r;
    logic [7:0]  rx_byte;
    logic [15:0] rd_word;

    assign rx_byte = {shreg_r, rx_bit};
    assign rd_word = reg_read(idx_r);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r   <= temp_alert_pkg::PH_IDLE;
            cnt_r     <= 4'h0;
            shreg_r   <= 7'h00;
            ack_r     <= 1'b0;
            tx_r      <= 8'h00;
            lo_hold_r <= 8'h00;
            hi_hold_r <= 8'h00;
            idx_r     <= temp_alert_pkg::IDX_RESULT;
            rd_clr_r  <= 1'b0;
            wr_r      <= 1'b0;
            wr_data_r <= 16'h0000;
        end else begin
            rd_clr_r <= 1'b0;
            wr_r     <= 1'b0;
            if (start_det) begin
                phase_r <= temp_alert_pkg::PH_ADDR;
                cnt_r   <= 4'h0;
                ack_r   <= 1'b0;
            end else if (stop_det) begin
                phase_r <= temp_alert_pkg::PH_IDLE;
                cnt_r   <= 4'h0;
                ack_r   <= 1'b0;
            end else if (bit_evt && phase_r != temp_alert_pkg::PH_IDLE) begin
                if (cnt_r == temp_alert_pkg::BIT_ACK) begin
                    cnt_r <= 4'h0;
                    // Master not acknowledging ends our transmission
                    if ((phase_r == temp_alert_pkg::PH_RD_HI ||
                         phase_r == temp_alert_pkg::PH_RD_LO) && rx_bit) begin
                        phase_r <= temp_alert_pkg::PH_IDLE;
                    end
                end else begin
                    shreg_r <= rx_byte[6:0];
                    cnt_r   <= cnt_r + 4'h1;
                    if (cnt_r == temp_alert_pkg::BIT_LAST) begin
                        unique case (phase_r)
                            temp_alert_pkg::PH_ADDR: begin
                                if (rx_byte[7:1] == DEV_ADDR) begin
                                    ack_r <= 1'b1;
                                    if (rx_byte[0]) begin
                                        phase_r   <= temp_alert_pkg::PH_RD_HI;
                                        tx_r      <= rd_word[15:8];
                                        lo_hold_r <= rd_word[7:0];
                                        rd_clr_r  <= 1'b1;
                                    end else begin
                                        phase_r <= temp_alert_pkg::PH_INDEX;
                                    end
                                end else begin
                                    ack_r   <= 1'b0;
                                    phase_r <= temp_alert_pkg::PH_IDLE;
                                end
                            end
                            temp_alert_pkg::PH_INDEX: begin
                                idx_r   <= rx_byte[1:0];
                                ack_r   <= 1'b1;
                                phase_r <= temp_alert_pkg::PH_WR_HI;
                            end
                            temp_alert_pkg::PH_WR_HI: begin
                                hi_hold_r <= rx_byte;
                                ack_r     <= 1'b1;
                                phase_r   <= temp_alert_pkg::PH_WR_LO;
                            end
                            temp_alert_pkg::PH_WR_LO: begin
                                wr_r      <= 1'b1;
                                wr_data_r <= {hi_hold_r, rx_byte};
                                ack_r     <= 1'b1;
                                phase_r   <= temp_alert_pkg::PH_WR_HI;
                            end
                            temp_alert_pkg::PH_RD_HI: begin
                                ack_r   <= 1'b0;
                                tx_r    <= lo_hold_r;
                                phase_r <= temp_alert_pkg::PH_RD_LO;
                            end
                            temp_alert_pkg::PH_RD_LO: begin
                                // Further reads repeat the same register
                                ack_r     <= 1'b0;
                                tx_r      <= rd_word[15:8];
                                lo_hold_r <= rd_word[7:0];
                                rd_clr_r  <= 1'b1;
                                phase_r   <= temp_alert_pkg::PH_RD_HI;
                            end
                            default: phase_r <= temp_alert_pkg::PH_IDLE;
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================================
    // Data line drive, changed only after a falling clock edge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (start_det || stop_det || phase_r == temp_alert_pkg::PH_IDLE) begin
                sda_oe <= 1'b0;
            end else if (scl_fall) begin
                if (cnt_r == temp_alert_pkg::BIT_ACK) begin
                    sda_oe <= ack_r;
                end else if (phase_r == temp_alert_pkg::PH_RD_HI ||
                             phase_r == temp_alert_pkg::PH_RD_LO) begin
                    sda_oe <= ~tx_r[3'(temp_alert_pkg::BIT_LAST - cnt_r)];
                end else begin
                    sda_oe <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Register storage
    logic sleep_wr;
    assign sleep_wr = wr_r && idx_r == temp_alert_pkg::IDX_CONFIG &&
                      wr_data_r[temp_alert_pkg::CFG_SLEEP];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            result_r <= temp_alert_pkg::RESULT_RST;
        end else if (conv.valid) begin
            result_r <= conv.value;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lower_r <= temp_alert_pkg::LOWER_RST;
            upper_r <= temp_alert_pkg::UPPER_RST;
        end else if (wr_r && idx_r == temp_alert_pkg::IDX_LOWER) begin
            lower_r <= wr_data_r & temp_alert_pkg::LIMIT_MASK;
        end else if (wr_r && idx_r == temp_alert_pkg::IDX_UPPER) begin
            upper_r <= wr_data_r & temp_alert_pkg::LIMIT_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || general_reset) begin
            config_r <= temp_alert_pkg::CONFIG_RST;
        end else begin
            // A software start of a single shot wins over its completion
            if (conv.valid) begin
                config_r[temp_alert_pkg::CFG_SHOT] <= 1'b0;
            end
            if (wr_r && idx_r == temp_alert_pkg::IDX_CONFIG) begin
                config_r <= (wr_data_r & temp_alert_pkg::CONFIG_WMSK) |
                            (config_r & ~temp_alert_pkg::CONFIG_WMSK);
            end
        end
    end

    // ==========================================================
    // Alarm state
    logic       latch_mode;
    logic [1:0] fcnt_sel;
    logic [1:0] fcnt_r;
    logic       watch_low_r;
    logic       watch_low;
    logic       cond;
    logic       fire;

    assign latch_mode = config_r[temp_alert_pkg::CFG_LATCH];
    assign fcnt_sel   = config_r[temp_alert_pkg::CFG_FCNT_LO +: 2];
    assign watch_low  = latch_mode ? watch_low_r : act_r;
    assign cond       = watch_low ? ($signed(conv.value) <= $signed(lower_r))
                                  : ($signed(conv.value) >= $signed(upper_r));
    assign fire       = conv.valid && cond && fcnt_r == fcnt_sel;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fcnt_r <= 2'h0;
        end else if (conv.valid) begin
            fcnt_r <= (cond && !fire) ? fcnt_r + 2'h1 : 2'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            act_r       <= 1'b0;
            watch_low_r <= 1'b0;
        end else if (!latch_mode) begin
            watch_low_r <= act_r;
            if (fire) begin
                act_r <= ~act_r;
            end
        end else begin
            // Clear first so a qualifying reading in the same cycle wins
            if (rd_clr_r || sleep_wr) begin
                act_r <= 1'b0;
            end
            if (fire) begin
                act_r       <= 1'b1;
                watch_low_r <= ~watch_low_r;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            level_r <= 1'b1;
        end else begin
            level_r <= config_r[temp_alert_pkg::CFG_LEVEL] ? act_r : ~act_r;
        end
    end

    assign alert        = level_r;
    assign sleep_select = config_r[temp_alert_pkg::CFG_SLEEP];
    assign single_shot  = config_r[temp_alert_pkg::CFG_SHOT];

endmodule

// ===== tb/temp_alert_core_asserts.sv
// Port-level checks for the temperature alert block
`timescale 1ns/1ps
module temp_alert_core_asserts (
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic                  scl_clk,
    input wire logic                  scl_in,
    input wire logic                  sda_in,
    input wire logic                  sda_out,
    input wire logic                  sda_oe,
    input wire temp_alert_pkg::conv_s conv,
    input wire logic                  general_reset,
    input wire logic                  alert,
    input wire logic                  sleep_select,
    input wire logic                  single_shot
);
    // ==========================================================
    // Bus activity trackers, saturating so they never wrap
    logic       scl_q;
    logic [4:0] idle_cnt;
    logic [4:0] fall_age;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q    <= 1'b1;
            idle_cnt <= 5'h1f;
            fall_age <= 5'h1f;
        end else begin
            scl_q    <= scl_in;
            idle_cnt <= (scl_in != scl_q) ? 5'h00 : idle_cnt + {4'h0, idle_cnt != 5'h1f};
            fall_age <= (scl_q && !scl_in) ? 5'h00 : fall_age + {4'h0, fall_age != 5'h1f};
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_bus_quiet;
        idle_cnt == 5'h1f;
    endsequence
    sequence s_cfg_default;
        !sleep_select && !single_shot;
    endsequence
    property p_open_drain;
        sda_oe |-> !sda_out;
    endproperty
    property p_rst_idle;
        disable iff (1'b0) !rst_n |=> !sda_oe && alert && !sleep_select && !single_shot;
    endproperty
    property p_oe_quiet_high;
        scl_in && scl_q |-> $stable(sda_oe);
    endproperty
    property p_oe_after_fall;
        $changed(sda_oe) |-> fall_age inside {[5'd1:5'd6]};
    endproperty
    property p_oe_idle_off;
        s_bus_quiet |-> !sda_oe;
    endproperty
    // Bus-caused moves are excluded by demanding a long quiet clock
    property p_alert_from_conv;
        s_bus_quiet ##0 ($changed(alert) && !$past(general_reset) && !$past(general_reset, 2)
            && !$past(general_reset, 3)) |-> $past(conv.valid, 2) || $past(conv.valid, 3);
    endproperty
    property p_sleep_from_bus;
        $changed(sleep_select) |-> idle_cnt != 5'h1f || $past(general_reset)
            || $past(general_reset, 2);
    endproperty
    property p_gen_reset;
        general_reset |-> ##[1:2] s_cfg_default;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs not idle in reset");
    a_oe_quiet_high: assert property (p_oe_quiet_high)
        else $error("data moved while clock high");
    a_oe_after_fall: assert property (p_oe_after_fall)
        else $error("data moved off clock fall timing");
    a_oe_idle_off: assert property (p_oe_idle_off)
        else $error("data held low on idle bus");
    a_alert_from_conv: assert property (p_alert_from_conv)
        else $error("alarm moved without conversion");
    a_sleep_from_bus: assert property (p_sleep_from_bus)
        else $error("sleep select moved without access");
    a_gen_reset: assert property (p_gen_reset)
        else $error("general reset left config set");
endmodule

bind temp_alert_core temp_alert_core_asserts chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_clk(scl_clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .conv(conv), .general_reset(general_reset), .alert(alert),
    .sleep_select(sleep_select), .single_shot(single_shot));

// ===== tb/i2c_master_model.sv
// Two-wire bus master that frames register transfers
`timescale 1ns/1ps
module i2c_master_model #(
    parameter logic [6:0] ADDR = 7'h48
) (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    localparam realtime Q = 31.25;
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    // ==========================================================
    // Clock pulses with data released, used during reset and just after its release
    task automatic tick(input int n);
        repeat (n) begin
            #(2 * Q) scl = 1'b0;
            #(2 * Q) scl = 1'b1;
        end
    endtask
    task automatic start();
        #Q sda_m = 1'b1;
        #Q scl = 1'b1;
        #Q sda_m = 1'b0;
        #Q scl = 1'b0;
    endtask
    task automatic stop();
        #Q sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #Q;
    endtask
    task automatic xfer_bit(input logic b, output logic r);
        #Q sda_m = b;
        #Q scl = 1'b1;
        #(2 * Q) r = sda;
        scl = 1'b0;
    endtask
    task automatic xfer_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                             output logic ack);
        for (int i = 7; i >= 0; i--) xfer_bit(tx[i], rx[i]);
        xfer_bit(mack, ack);
    endtask
    task automatic probe(input logic [6:0] a, output logic ok);
        logic [7:0] rx;
        logic       a0;
        start();
        xfer_byte({a, 1'b0}, 1'b1, rx, a0);
        stop();
        ok = !a0;
    endtask
    task automatic wr_reg(input logic [1:0] idx, input logic [15:0] d, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2, a3;
        start();
        xfer_byte({ADDR, 1'b0}, 1'b1, rx, a0);
        xfer_byte({6'h00, idx}, 1'b1, rx, a1);
        xfer_byte(d[15:8], 1'b1, rx, a2);
        xfer_byte(d[7:0], 1'b1, rx, a3);
        stop();
        ok = !(a0 | a1 | a2 | a3);
    endtask
    task automatic rd_reg(input logic [1:0] idx, output logic [15:0] d, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2, mk;
        start();
        xfer_byte({ADDR, 1'b0}, 1'b1, rx, a0);
        xfer_byte({6'h00, idx}, 1'b1, rx, a1);
        stop();
        start();
        xfer_byte({ADDR, 1'b1}, 1'b1, rx, a2);
        xfer_byte(8'hff, 1'b0, d[15:8], mk);
        xfer_byte(8'hff, 1'b1, d[7:0], mk);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
endmodule

// ===== tb/temp_threshold_alert_logic_tb.sv
// Self-checking bench for the temperature alert block
`timescale 1ns/1ps
module temp_threshold_alert_logic_tb;
    localparam logic [6:0] DEV = 7'h48; // Arbitrary target address
    logic                  clk_sys, rst_n, scl, sda_m, sda, sda_oe, sda_out;
    logic                  gen_rst, alert, sleep_sel, shot, ok;
    logic [15:0]           rd_val;
    temp_alert_pkg::conv_s conv;
    int                    n_errors, total_checks, cycles;
    // Pull-up on the data line, either party may pull low
    assign sda = sda_m & ~(sda_oe & ~sda_out);
    temp_alert_core #(.DEV_ADDR(DEV)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .scl_clk(scl),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv(conv),
        .general_reset(gen_rst), .alert(alert), .sleep_select(sleep_sel), .single_shot(shot));
    i2c_master_model #(.ADDR(DEV)) master_u (.scl(scl), .sda_m(sda_m), .sda(sda));
    // ==========================================================
    // Clock, timeout and verdict
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ==========================================================
    // Compare and access tasks
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] idx, input logic [15:0] d);
        master_u.wr_reg(idx, d, ok);
        chk1(ok, 1'b1);
    endtask
    task automatic rd(input logic [1:0] idx, input logic [15:0] exp);
        master_u.rd_reg(idx, rd_val, ok);
        chk1(ok, 1'b1);
        chk16(rd_val, exp);
    endtask
    task automatic conv_step(input logic [15:0] v, input logic exp_alert);
        @(negedge clk_sys);
        conv.valid = 1'b1;
        conv.value = v;
        @(negedge clk_sys);
        conv.valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk1(alert, exp_alert);
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        rst_n = 1'b0;
        gen_rst = 1'b0;
        conv = '0;
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
        // Reset stretched so the link domain also sees clock edges
        fork
            master_u.tick(4);
            repeat (64) @(negedge clk_sys);
        join
        rst_n = 1'b1;
        // Link domain leaves reset only after two more serial clock rises
        master_u.tick(2);
        repeat (8) @(negedge clk_sys);
        chk1(alert, 1'b1);
        rd(temp_alert_pkg::IDX_RESULT, 16'h0000);
        rd(temp_alert_pkg::IDX_LOWER, 16'h2580);
        rd(temp_alert_pkg::IDX_UPPER, 16'h2800);
        rd(temp_alert_pkg::IDX_CONFIG, 16'h40a0);
        master_u.probe(DEV ^ 7'h01, ok);
        chk1(ok, 1'b0);
        wr(temp_alert_pkg::IDX_UPPER, 16'h190f);
        rd(temp_alert_pkg::IDX_UPPER, 16'h1900);
        wr(temp_alert_pkg::IDX_LOWER, 16'h0c8a);
        rd(temp_alert_pkg::IDX_LOWER, 16'h0c80);
        wr(temp_alert_pkg::IDX_RESULT, 16'h1234);
        rd(temp_alert_pkg::IDX_RESULT, 16'h0000);
        // Comparator mode for every fault count; limits hit exactly
        for (int n = 1; n <= 4; n++) begin
            wr(temp_alert_pkg::IDX_CONFIG, 16'((n - 1) << 11));
            repeat (n - 1) conv_step(16'h1900, 1'b1);
            conv_step(16'h1000, 1'b1);
            repeat (n - 1) conv_step(16'h1900, 1'b1);
            conv_step(16'h1900, 1'b0);
            conv_step(16'h1000, 1'b0);
            repeat (n - 1) conv_step(16'h0c80, 1'b0);
            conv_step(16'h0c80, 1'b1);
        end
        wr(temp_alert_pkg::IDX_CONFIG, 16'h8000);
        chk1(shot, 1'b1);
        conv_step(16'hff00, 1'b1);
        chk1(shot, 1'b0);
        rd(temp_alert_pkg::IDX_RESULT, 16'hff00);
        // Interrupt mode, active high, one fault
        wr(temp_alert_pkg::IDX_CONFIG, 16'h0600);
        chk1(alert, 1'b0);
        conv_step(16'h1900, 1'b1);
        conv_step(16'h1000, 1'b1);
        rd(temp_alert_pkg::IDX_LOWER, 16'h0c80);
        chk1(alert, 1'b0);
        conv_step(16'h1900, 1'b0);
        conv_step(16'h0c80, 1'b1);
        rd(temp_alert_pkg::IDX_UPPER, 16'h1900);
        chk1(alert, 1'b0);
        conv_step(16'h1900, 1'b1);
        wr(temp_alert_pkg::IDX_CONFIG, 16'h0700);
        chk1(alert, 1'b0);
        chk1(sleep_sel, 1'b1);
        @(negedge clk_sys);
        gen_rst = 1'b1;
        @(negedge clk_sys);
        gen_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk1(sleep_sel, 1'b0);
        chk1(alert, 1'b1);
        conv_step(16'h1900, 1'b0);
        rd(temp_alert_pkg::IDX_RESULT, 16'h1900);
        chk1(alert, 1'b0);
        report_and_stop();
    end
endmodule
